// *** verilog/pcg_clock_gen.sv ***
// Purpose: Clock generation with reference select, loop model and write guard
// Assumes: All clocks except the crystal input level are modelled as one-cycle enable pulses on clk
// Notes: The loop is a phase accumulator steered by period comparison
//
// Design decisions made here: the register offsets and the plain strobed port.

`timescale 1ns/1ps
`default_nettype none

module pcg_clock_gen (
	input wire logic clk,
	input wire logic srst,
	input wire pcg_pkg::pcg_addr_t regAddr,
	input wire pcg_pkg::pcg_data_t wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output var pcg_pkg::pcg_data_t rdData,
	input wire logic specialMode,
	input wire logic crystalInput,
	output logic referenceTick,
	output logic vcoTick,
	output logic feedbackTick,
	output logic pllOutTick,
	output logic busTick,
	output logic irqReq
);
	import pcg_pkg::*;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Write hit on one offset
	function automatic logic wrHit(input pcg_addr_t a, input pcg_addr_t ofs,
		input logic we);
		return we && (a == ofs);
	endfunction

	// Magnitude of a period difference
	function automatic logic [15:0] absDiff(input logic [15:0] a, input logic [15:0] b);
		return (a > b) ? (a - b) : (b - a);
	endfunction

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	pcg_data_t synth_ff;     // Vco range and multiply field
	pcg_data_t ref_divide_field_ff;    // Reference range and divide field
	pcg_data_t post_divide_field_ff;   // Post divide field
	pcg_data_t clkSel_ff;    // Source select
	pcg_data_t pllCfg_ff;    // Loop options, stored only
	pcg_data_t trimHi_ff;    // Rc trim, stored only
	pcg_data_t trimLo_ff;
	pcg_data_t osc_ff;       // Crystal enable, window, filter ratio
	pcg_data_t test_ff;      // Factory test
	pcg_data_t irqEn_ff;     // Interrupt enables
	pcg_data_t rdData_ff;    // Read data register
	logic guard_ff;          // Guard closed
	logic pinsEn_ff;         // Crystal pins reserved, sticky
	logic settleIf_ff;       // Settled changed
	logic xtalIf_ff;         // Qualified changed
	logic qualPrev_ff;       // Qualified, last cycle
	logic irq_ff;
	pcg_lock_t lock_ff, nxt_lock;

	// Loop model state
	logic [15:0] phase_ff;   // Vco phase accumulator
	logic [15:0] inc_ff;     // Vco phase step, sets frequency
	logic vcoTick_ff;
	logic [15:0] refCnt_ff, refPer_ff;  // Reference period in clk cycles
	logic [15:0] fbCnt_ff, fbPer_ff;    // Feedback period in clk cycles
	logic fbSeen_ff;         // A feedback period has been measured

	logic wrGuarded, oscWr, crystal_enable, settled, qualNow, rcTick, xtalDivTick, pllDivTick;
	logic [16:0] phaseSum;
	logic [15:0] err, step;

	pcg_filt_if fif ();

	// ---------------------------------------------------------------
	// Write decode
	// ---------------------------------------------------------------
	assign wrGuarded = wrStrobe && !guard_ff;
	// Crystal control also needs the loop as bus source
	assign oscWr = wrHit(regAddr, OFS_OSC, wrGuarded) && clkSel_ff[F_PLL_SOURCE_SELECT];
	assign crystal_enable = osc_ff[F_CRYSTAL_ENABLE];
	assign settled = (lock_ff == LK_HELD);

	// Guard register: key opens, anything else closes
	always_ff @(posedge clk)
	begin
		if (srst)
			guard_ff <= RST_GUARD;
		else if (wrHit(regAddr, OFS_GUARD, wrStrobe))
			guard_ff <= (wrData != GUARD_KEY);
	end

	// Guarded loop configuration
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			synth_ff <= RST_SYNTH;
			ref_divide_field_ff <= RST_REF_DIVIDE_FIELD;
			pllCfg_ff <= RST_ZERO;
			trimHi_ff <= RST_ZERO;
			trimLo_ff <= RST_ZERO;
		end
		else
		begin
			if (wrHit(regAddr, OFS_SYNTH, wrGuarded))
				synth_ff <= wrData;
			if (wrHit(regAddr, OFS_REF_DIVIDE_FIELD, wrGuarded))
				ref_divide_field_ff <= wrData;
			if (wrHit(regAddr, OFS_PLLCFG, wrGuarded))
				pllCfg_ff <= wrData;
			if (wrHit(regAddr, OFS_TRIMHI, wrGuarded))
				trimHi_ff <= wrData;
			if (wrHit(regAddr, OFS_TRIMLO, wrGuarded))
				trimLo_ff <= wrData;
		end
	end

	// Source select; losing crystal status forces the loop back in
	always_ff @(posedge clk)
	begin
		if (srst)
			clkSel_ff <= RST_CLKSEL;
		else if (qualPrev_ff && !qualNow)
			clkSel_ff[F_PLL_SOURCE_SELECT] <= 1'b1;
		else if (wrHit(regAddr, OFS_CLKSEL, wrGuarded))
			clkSel_ff <= wrData;
	end

	// Crystal control; the pins bit is read-only and sticky
	always_ff @(posedge clk)
	begin
		if (srst)
			osc_ff <= RST_ZERO;
		else if (oscWr)
			osc_ff <= {wrData[7:6], 1'b0, wrData[4:0]};
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			pinsEn_ff <= 1'b0;
		else if (crystal_enable)
			pinsEn_ff <= 1'b1;
	end

	// Unguarded registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			post_divide_field_ff <= RST_POST_DIVIDE_FIELD;
			irqEn_ff <= RST_ZERO;
			test_ff <= RST_ZERO;
		end
		else
		begin
			if (wrHit(regAddr, OFS_POST_DIVIDE_FIELD, wrStrobe))
				post_divide_field_ff <= {3'h0, wrData[4:0]};
			if (wrHit(regAddr, OFS_IRQEN, wrStrobe))
				irqEn_ff <= {3'h0, wrData[F_SETTLEIE], 2'h0, wrData[F_XTALIE], 1'b0};
			// Outside special mode the write is dropped
			if (wrHit(regAddr, OFS_TEST, wrStrobe) && specialMode)
				test_ff <= wrData;
		end
	end

	// ---------------------------------------------------------------
	// Reference path
	// ---------------------------------------------------------------
	// Trimmed rc stand-in: one pulse per microsecond
	pcg_tick_div #(.W(8)) uRcDiv (
		.clk(clk),
		.srst(srst),
		.en(1'b1),
		.div(RC_DIV_VAL),
		.tick(rcTick)
	);

	// Crystal edges after the filter, divided by field plus one
	pcg_tick_div #(.W(4)) uRefDiv (
		.clk(clk),
		.srst(srst),
		.en(fif.xtalTick),
		.div(ref_divide_field_ff[3:0]),
		.tick(xtalDivTick)
	);

	assign referenceTick = crystal_enable ? xtalDivTick : rcTick;

	// Filter is fed at the vco rate; a control write restarts it
	assign fif.sampleEn = vcoTick_ff;
	assign fif.xtalIn = crystalInput;
	assign fif.enable = crystal_enable && !oscWr;
	assign fif.wide = osc_ff[F_FILTER_WINDOW_WIDE];
	assign fif.ratio = osc_ff[4:0];
	assign qualNow = fif.qualified;

	pcg_osc_filter uFilt (
		.clk(clk),
		.srst(srst),
		.fi(fif)
	);

	// ---------------------------------------------------------------
	// Vco model
	// ---------------------------------------------------------------
	// Carry out of the accumulator is one vco cycle
	assign phaseSum = {1'b0, phase_ff} + {1'b0, inc_ff};

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			phase_ff <= '0;
			vcoTick_ff <= 1'b0;
		end
		else
		begin
			phase_ff <= phaseSum[15:0];
			vcoTick_ff <= phaseSum[16];
		end
	end

	assign vcoTick = vcoTick_ff;

	// Feedback divides by twice the multiplier, so it meets the reference
	pcg_tick_div #(.W(7)) uFbDiv (
		.clk(clk),
		.srst(srst),
		.en(vcoTick_ff),
		.div({synth_ff[5:0], 1'b1}),
		.tick(feedbackTick)
	);

	// Period meters; they saturate so a stalled clock reads as slow
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			refCnt_ff <= '0;
			refPer_ff <= '0;
		end
		else if (referenceTick)
		begin
			refCnt_ff <= 16'h0001;
			refPer_ff <= refCnt_ff;
		end
		else if (refCnt_ff != 16'hFFFF)
			refCnt_ff <= refCnt_ff + 16'h0001;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			fbCnt_ff <= '0;
			fbPer_ff <= '0;
			fbSeen_ff <= 1'b0;
		end
		else if (feedbackTick)
		begin
			fbCnt_ff <= 16'h0001;
			fbPer_ff <= fbCnt_ff;
			fbSeen_ff <= 1'b1;
		end
		else if (fbCnt_ff != 16'hFFFF)
			fbCnt_ff <= fbCnt_ff + 16'h0001;
	end

	// Proportional step; large errors are clipped to keep the loop damped
	assign err = absDiff(fbPer_ff, refPer_ff);
	assign step = (err > 16'h0FFF) ? 16'hFFF0 : {err[11:0], 4'h0};

	// Frequency correction once per reference period
	always_ff @(posedge clk)
	begin
		if (srst)
			inc_ff <= VCO_INC_RST;
		else if (referenceTick && fbSeen_ff)
		begin
			if (fbPer_ff > refPer_ff)
				inc_ff <= (inc_ff > 16'hFFFF - step) ? 16'hFFFF : inc_ff + step;
			else
				inc_ff <= (inc_ff <= step) ? 16'h0001 : inc_ff - step;
		end
	end

	// ---------------------------------------------------------------
	// Lock detector
	// ---------------------------------------------------------------
	// Hysteresis between lock and unlock tolerances
	always_comb
	begin
		nxt_lock = lock_ff;
		unique case (lock_ff)
			LK_HUNT:
				if (referenceTick && fbSeen_ff && (err <= LOCK_TOL))
					nxt_lock = LK_HELD;
			LK_HELD:
				if (referenceTick && (err > UNLOCK_TOL))
					nxt_lock = LK_HUNT;
			default:
				nxt_lock = LK_HUNT;
		endcase
		// Noise or a crystal control write drops the lock at once
		if (fif.noise || oscWr)
			nxt_lock = LK_HUNT;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			lock_ff <= LK_HUNT;
		else
			lock_ff <= nxt_lock;
	end

	// ---------------------------------------------------------------
	// Output dividers
	// ---------------------------------------------------------------
	// Unsettled output runs at vco over four whatever the field holds
	pcg_tick_div #(.W(5)) uPostDiv (
		.clk(clk),
		.srst(srst),
		.en(vcoTick_ff),
		.div(settled ? post_divide_field_ff[4:0] : UNLOCKED_POST_DIVIDE_FIELD),
		.tick(pllOutTick)
	);

	pcg_tick_div #(.W(1)) uBusDiv (
		.clk(clk),
		.srst(srst),
		.en(pllOutTick),
		.div(1'b1),
		.tick(pllDivTick)
	);

	// Without the loop, the filtered crystal drives the bus
	assign busTick = clkSel_ff[F_PLL_SOURCE_SELECT] ? pllDivTick : fif.xtalTick;

	// ---------------------------------------------------------------
	// Status flags
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
			qualPrev_ff <= 1'b0;
		else
			qualPrev_ff <= qualNow;
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (srst)
			settleIf_ff <= 1'b0;
		else if ((nxt_lock != lock_ff) || fif.noise)
			settleIf_ff <= 1'b1;
		else if (wrHit(regAddr, OFS_FLAGS, wrStrobe) && wrData[F_SETTLEIF])
			settleIf_ff <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			xtalIf_ff <= 1'b0;
		else if ((qualNow != qualPrev_ff) || fif.noise)
			xtalIf_ff <= 1'b1;
		else if (wrHit(regAddr, OFS_FLAGS, wrStrobe) && wrData[F_XTALIF])
			xtalIf_ff <= 1'b0;
	end

	// Request follows enabled flags; software must clear enables before stop
	always_ff @(posedge clk)
	begin
		if (srst)
			irq_ff <= 1'b0;
		else
			irq_ff <= (settleIf_ff && irqEn_ff[F_SETTLEIE])
				|| (xtalIf_ff && irqEn_ff[F_XTALIE]);
	end

	assign irqReq = irq_ff;

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------
	// Settled and qualified bits are read-only views of live state
	always_ff @(posedge clk)
	begin
		if (srst)
			rdData_ff <= '0;
		else if (rdStrobe)
		begin
			unique case (regAddr)
				OFS_SYNTH: rdData_ff <= synth_ff;
				OFS_REF_DIVIDE_FIELD: rdData_ff <= ref_divide_field_ff;
				OFS_POST_DIVIDE_FIELD: rdData_ff <= post_divide_field_ff;
				OFS_FLAGS: rdData_ff <= {3'h0, settleIf_ff, settled, 1'b0, xtalIf_ff, qualNow};
				OFS_IRQEN: rdData_ff <= irqEn_ff;
				OFS_CLKSEL: rdData_ff <= clkSel_ff;
				OFS_PLLCFG: rdData_ff <= pllCfg_ff;
				OFS_TRIMHI: rdData_ff <= trimHi_ff;
				OFS_TRIMLO: rdData_ff <= trimLo_ff;
				OFS_OSC: rdData_ff <= {osc_ff[7:6], pinsEn_ff, osc_ff[4:0]};
				OFS_GUARD: rdData_ff <= {7'h00, guard_ff};
				OFS_TEST: rdData_ff <= test_ff;
				default: rdData_ff <= 8'h00;
			endcase
		end
		else
			rdData_ff <= '0;
	end

	assign rdData = rdData_ff;
endmodule

`default_nettype wire

// *** shared/pcg_pkg.sv ***
// Purpose: Shared constants and types of the clock generator with write guard
// Assumes: 8-bit register data, 4-bit register address, 200 MHz system clock
// Notes: Register offsets, field positions, reset values and timing counts live here

package pcg_pkg;

	// ---------------------------------------------------------------
	// Bus types
	// ---------------------------------------------------------------
	typedef logic [3:0] pcg_addr_t;
	typedef logic [7:0] pcg_data_t;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam pcg_addr_t OFS_SYNTH = 4'h0;
	localparam pcg_addr_t OFS_REF_DIVIDE_FIELD = 4'h1;
	localparam pcg_addr_t OFS_POST_DIVIDE_FIELD = 4'h2;
	localparam pcg_addr_t OFS_FLAGS = 4'h3;
	localparam pcg_addr_t OFS_IRQEN = 4'h4;
	localparam pcg_addr_t OFS_CLKSEL = 4'h5;
	localparam pcg_addr_t OFS_PLLCFG = 4'h6;
	localparam pcg_addr_t OFS_TRIMHI = 4'h7;
	localparam pcg_addr_t OFS_TRIMLO = 4'h8;
	localparam pcg_addr_t OFS_OSC = 4'h9;
	localparam pcg_addr_t OFS_GUARD = 4'hA;
	localparam pcg_addr_t OFS_TEST = 4'hB;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam pcg_data_t RST_SYNTH = 8'h5F;   // Vco range 01, multiply field 0x1F
	localparam pcg_data_t RST_REF_DIVIDE_FIELD = 8'h00;
	localparam pcg_data_t RST_POST_DIVIDE_FIELD = 8'h03;
	localparam pcg_data_t RST_CLKSEL = 8'h80;  // Bus clock from loop output
	localparam pcg_data_t RST_ZERO = 8'h00;
	localparam logic RST_GUARD = 1'b0;

	// ---------------------------------------------------------------
	// Field positions and special values
	// ---------------------------------------------------------------
	localparam int F_RANGE_LSB = 6;
	localparam int F_PLL_SOURCE_SELECT = 7;
	localparam int F_CRYSTAL_ENABLE = 7;
	localparam int F_FILTER_WINDOW_WIDE = 6;
	localparam int F_PINSEN = 5;
	localparam int F_SETTLEIF = 4;
	localparam int F_SETTLED = 3;
	localparam int F_XTALIF = 1;
	localparam int F_QUAL = 0;
	localparam int F_SETTLEIE = 4;
	localparam int F_XTALIE = 1;
	localparam int F_GUARD = 0;
	localparam pcg_data_t GUARD_KEY = 8'h26;
	localparam logic [4:0] UNLOCKED_POST_DIVIDE_FIELD = 5'h03;  // Divide by four

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int RC_PERIOD_NS = 1000;
	localparam int RC_DIV_CYC = RC_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [7:0] RC_DIV_VAL = 8'(RC_DIV_CYC - 1);
	localparam int CLK_MHZ = 1000 / CLK_PERIOD_NS;
	localparam int VCO_RST_MHZ = 64;
	localparam logic [15:0] VCO_INC_RST = 16'((VCO_RST_MHZ * 65536) / CLK_MHZ);
	localparam logic [15:0] LOCK_TOL = 16'h0002;
	localparam logic [15:0] UNLOCK_TOL = 16'h0004;
	localparam logic [3:0] QUAL_EDGES = 4'h8;

	// Lock detector states
	typedef enum logic [1:0] {LK_HUNT = 2'b01, LK_HELD = 2'b10} pcg_lock_t;

endpackage

// *** shared/pcg_filt_if.sv ***
// Purpose: Carries the crystal filter controls and results between modules
// Assumes: One clock domain, signals are plain levels or one-cycle pulses
// Notes: ctrl side is the clock generator, filt side is the spike filter

`timescale 1ns/1ps
`default_nettype none

interface pcg_filt_if;
	logic sampleEn;     // Vco rate sample pulse
	logic xtalIn;       // Raw crystal level
	logic enable;       // Crystal path enabled
	logic wide;         // Wide edge window
	logic [4:0] ratio;  // Half period in vco cycles, 0 = off
	logic xtalTick;     // Filtered crystal rising edge
	logic noise;        // Unfilterable disturbance pulse
	logic qualified;    // Crystal judged stable
	modport ctrl (output sampleEn, xtalIn, enable, wide, ratio,
		input xtalTick, noise, qualified);
	modport filt (input sampleEn, xtalIn, enable, wide, ratio,
		output xtalTick, noise, qualified);
endinterface

`default_nettype wire

// *** verilog/pcg_tick_div.sv ***
// Purpose: Divides an enable pulse stream by a programmable ratio
// Assumes: div holds ratio minus one
// Notes: Compares with >= so a lowered ratio never stalls the count

`timescale 1ns/1ps
`default_nettype none

module pcg_tick_div #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic en,
	input wire logic [W-1:0] div,
	output logic tick
);
	logic [W-1:0] cnt_ff;  // Input pulses since last output

	// Output pulse on the last input pulse of each period
	assign tick = en && (cnt_ff >= div);

	// ---------------------------------------------------------------
	// Counter
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
			cnt_ff <= '0;
		else if (tick)
			cnt_ff <= '0;
		else if (en)
			cnt_ff <= cnt_ff + 1'b1;
	end
endmodule

`default_nettype wire

// *** verilog/pcg_osc_filter.sv ***
// Purpose: Adaptive spike filter and noise detector for the crystal clock
// Assumes: sampleEn pulses at the vco rate
// Notes: Edges outside the expected window are dropped, not passed on

`timescale 1ns/1ps
`default_nettype none

module pcg_osc_filter (
	input wire logic clk,
	input wire logic srst,
	pcg_filt_if.filt fi
);
	import pcg_pkg::*;

	logic prev_ff;        // Last sampled crystal level
	logic [5:0] cnt_ff;   // Vco samples since last accepted edge
	logic [3:0] good_ff;  // Clean rising edges counted
	logic qual_ff;        // Qualified status
	logic filtOn, detOn, edgeSeen, inWin, accept;
	logic [5:0] lo, hi;

	// ---------------------------------------------------------------
	// Window and mode decode
	// ---------------------------------------------------------------
	assign filtOn = (fi.ratio != 5'h00);
	assign detOn = (fi.ratio >= 5'h04) || ((fi.ratio >= 5'h02) && !fi.wide);
	// Window is three samples wide or one, centred on the half period
	assign lo = fi.wide ? ({1'b0, fi.ratio} - 6'h01) : {1'b0, fi.ratio};
	assign hi = fi.wide ? ({1'b0, fi.ratio} + 6'h01) : {1'b0, fi.ratio};
	assign edgeSeen = fi.sampleEn && (fi.xtalIn != prev_ff);
	assign inWin = (cnt_ff >= lo) && (cnt_ff <= hi);
	// Bypassed filter passes every edge
	assign accept = edgeSeen && (!filtOn || inWin);
	assign fi.noise = fi.enable && edgeSeen && filtOn && detOn && !inWin;
	assign fi.xtalTick = fi.enable && accept && fi.xtalIn;
	assign fi.qualified = qual_ff;

	// ---------------------------------------------------------------
	// Sampler and window counter
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst)
			prev_ff <= 1'b0;
		else if (fi.sampleEn)
			prev_ff <= fi.xtalIn;
	end

	// Saturates so a stopped crystal cannot wrap into a false window
	always_ff @(posedge clk)
	begin
		if (srst || !fi.enable)
			cnt_ff <= '0;
		else if (accept)
			cnt_ff <= 6'h01;
		else if (fi.sampleEn && (cnt_ff != 6'h3F))
			cnt_ff <= cnt_ff + 6'h01;
	end

	// ---------------------------------------------------------------
	// Qualification
	// ---------------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (srst || !fi.enable || fi.noise)
		begin
			good_ff <= '0;
			qual_ff <= 1'b0;
		end
		else if (accept && fi.xtalIn && !qual_ff)
		begin
			good_ff <= good_ff + 4'h1;
			qual_ff <= (good_ff == QUAL_EDGES - 4'h1);
		end
	end
endmodule

`default_nettype wire

// *** dv/pcg_clock_gen_asserts.sv ***
// Purpose: Port checks for the clock generator
// Assumes: Bound into pcg_clock_gen, one clock domain
// Notes: Tick checks assume the rc reference is in use

`timescale 1ns/1ps
`default_nettype none

module pcg_clock_gen_asserts (
	input wire logic clk,
	input wire logic srst,
	input wire pcg_pkg::pcg_addr_t regAddr,
	input wire pcg_pkg::pcg_data_t wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	input wire pcg_pkg::pcg_data_t rdData,
	input wire logic referenceTick,
	input wire logic vcoTick,
	input wire logic feedbackTick,
	input wire logic pllOutTick,
	input wire logic irqReq
);
	import pcg_pkg::*;
	// ----------------------------------------
	// Guard access steps
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	sequence s_key;
		wrStrobe && regAddr == OFS_GUARD && wrData == GUARD_KEY;
	endsequence
	sequence s_other;
		wrStrobe && regAddr == OFS_GUARD && wrData != GUARD_KEY;
	endsequence
	sequence s_grd;
		rdStrobe && regAddr == OFS_GUARD;
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_guard_open: assert property (s_key ##[1:2] s_grd |=> !rdData[F_GUARD])
		else $error("guard still closed after key");
	a_guard_close: assert property (s_other ##[1:2] s_grd |=> rdData[F_GUARD])
		else $error("guard not closed");
	a_read_idle: assert property (!$past(rdStrobe) |-> rdData == 8'h00)
		else $error("read data outside read slot");
	a_read_unmapped: assert property (rdStrobe && regAddr > OFS_TEST |=> rdData == 8'h00)
		else $error("unmapped read not zero");
	a_pll_on_vco: assert property (pllOutTick |-> vcoTick)
		else $error("loop output off vco pulse");
	a_fb_on_vco: assert property (feedbackTick |-> vcoTick)
		else $error("feedback off vco pulse");
	a_ref_spacing: assert property (referenceTick |=> !referenceTick [*8])
		else $error("reference pulses too close");
	a_irq_reset: assert property ($fell(srst) |-> !irqReq)
		else $error("request right after reset");
	a_vco_reset: assert property ($fell(srst) |-> !vcoTick)
		else $error("vco pulse right after reset");
endmodule

bind pcg_clock_gen pcg_clock_gen_asserts u_chk (.clk(clk), .srst(srst),
	.regAddr(regAddr), .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
	.rdData(rdData), .referenceTick(referenceTick), .vcoTick(vcoTick),
	.feedbackTick(feedbackTick), .pllOutTick(pllOutTick), .irqReq(irqReq));

`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench for the clock generator
// Assumes: Reset register values and rc reference
// Notes: Crystal is a free-running counter bit, filter left bypassed

`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import pcg_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	pcg_addr_t regAddr = 4'h0;
	pcg_data_t wrData = 8'h00;
	logic wrStrobe = 1'b0;
	logic rdStrobe = 1'b0;
	logic specialMode = 1'b0;
	logic xtalRun = 1'b0; // Crystal stand-in running
	logic [3:0] xtalCnt = 4'h0; // Crystal stand-in, bit 3 is the pin, period 16 clocks
	pcg_data_t rdData;
	logic referenceTick, vcoTick, feedbackTick, pllOutTick, busTick, irqReq;
	int fails = 0;
	int check_count = 0;
	logic [15:0] seed = 16'h49BB; // Starts at 18875
	pcg_data_t g, d, synthExp, testExp;
	// ----------------------------------------
	// Clock and design
	// ----------------------------------------
	always #2.5 clk = ~clk;
	// Crystal stand-in, changes on the rising edge like every other input
	always @(posedge clk)
		if (xtalRun)
			xtalCnt <= xtalCnt + 4'h1;
	pcg_clock_gen DUT (.clk(clk), .srst(srst), .regAddr(regAddr), .wrData(wrData),
		.wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
		.specialMode(specialMode), .crystalInput(xtalCnt[3]), .referenceTick(referenceTick),
		.vcoTick(vcoTick), .feedbackTick(feedbackTick), .pllOutTick(pllOutTick),
		.busTick(busTick), .irqReq(irqReq));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [15:0] xs(logic [15:0] s);
		s ^= s << 7;
		s ^= s >> 9;
		s ^= s << 8;
		return s;
	endfunction
	// Guard reads 0 only after the key
	function automatic pcg_data_t gexp(pcg_data_t v);
		return (v == GUARD_KEY) ? 8'h00 : 8'h01;
	endfunction
	// Start and counted event of each span kind
	function automatic logic ev(int sel, logic cnt);
		case (sel)
			0: return cnt ? 1'b1 : referenceTick;
			1: return cnt ? vcoTick : pllOutTick;
			3: return cnt ? (xtalCnt == 4'h8) : referenceTick;
			default: return cnt ? pllOutTick : busTick;
		endcase
	endfunction
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(string nm, pcg_data_t seen, pcg_data_t exp);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rst();
		srst <= 1'b1;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(pcg_addr_t a, pcg_data_t v);
		@(posedge clk);
		regAddr <= a;
		wrData <= v;
		wrStrobe <= 1'b1;
		@(posedge clk);
		wrStrobe <= 1'b0;
	endtask
	// Read data are taken in the one cycle they stand
	task automatic rd(pcg_addr_t a, output pcg_data_t v);
		@(posedge clk);
		regAddr <= a;
		rdStrobe <= 1'b1;
		@(posedge clk);
		rdStrobe <= 1'b0;
		#1;
		v = rdData;
	endtask
	task automatic rc(pcg_addr_t a, pcg_data_t exp, string nm);
		pcg_data_t v;
		rd(a, v);
		chk(nm, v, exp);
	endtask
	// Polls the flags until settled shows, bounded
	task automatic wait_settled();
		pcg_data_t v;
		int t;
		t = 0;
		v = 8'h00;
		while (v[F_SETTLED] !== 1'b1 && t < 40)
		begin
			repeat (50) @(posedge clk);
			rd(OFS_FLAGS, v);
			t++;
		end
		if (v[F_SETTLED] !== 1'b1)
		begin
			fails++;
			complete_run();
		end
	endtask
	// Counts events between two start events, bounded
	task automatic span(int sel, int exp);
		int n;
		int t;
		n = 0;
		t = 0;
		while (!ev(sel, 1'b0) && t < 2000)
		begin
			@(posedge clk);
			#1;
			t++;
		end
		do
		begin
			@(posedge clk);
			#1;
			t++;
			n += ev(sel, 1'b1);
		end while (!ev(sel, 1'b0) && t < 2000);
		if (t >= 2000)
		begin
			fails++;
			complete_run();
		end
		else
			chk("span", 8'(n), 8'(exp));
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		rst();
		rc(OFS_SYNTH, RST_SYNTH, "synth");
		rc(OFS_REF_DIVIDE_FIELD, RST_REF_DIVIDE_FIELD, "ref_divide_field");
		rc(OFS_POST_DIVIDE_FIELD, RST_POST_DIVIDE_FIELD, "post_divide_field");
		rc(OFS_CLKSEL, RST_CLKSEL, "clksel");
		rc(OFS_GUARD, 8'h00, "guard");
		rc(4'hF, 8'h00, "unmapped");
		$display("test reset values done");
		span(0, RC_DIV_CYC);
		span(1, 4);
		span(2, 2);
		$display("test clock ratios done");
		synthExp = RST_SYNTH;
		for (int i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			g = i[0] ? seed[15:8] : GUARD_KEY;
			d = seed[7:0];
			wr(OFS_GUARD, g);
			rc(OFS_GUARD, gexp(g), "guard");
			wr(OFS_SYNTH, d);
			if (g == GUARD_KEY)
				synthExp = d;
			rc(OFS_SYNTH, synthExp, "synth");
		end
		$display("test guard done");
		testExp = 8'h00;
		for (int m = 0; m < 2; m++)
		begin
			seed = xs(seed);
			specialMode <= m[0];
			wr(OFS_TEST, seed[7:0]);
			if (m == 1)
				testExp = seed[7:0];
			rc(OFS_TEST, testExp, "test");
		end
		$display("test special mode done");
		wr(OFS_GUARD, GUARD_KEY);
		wr(OFS_REF_DIVIDE_FIELD, 8'h01);
		xtalRun <= 1'b1;
		wr(OFS_OSC, 8'h80);
		rc(OFS_OSC, 8'hA0, "osc");
		span(3, 2);
		$display("test crystal reference done");
		rst();
		rc(OFS_SYNTH, RST_SYNTH, "synth");
		rc(OFS_GUARD, 8'h00, "guard");
		chk("irq", {7'h00, irqReq}, 8'h00);
		$display("test second reset done");
		wr(OFS_IRQEN, 8'h10);
		wait_settled();
		chk("irq", {7'h00, irqReq}, 8'h01);
		wr(OFS_FLAGS, 8'h12);
		rc(OFS_FLAGS, 8'h08, "flags");
		chk("irq", {7'h00, irqReq}, 8'h00);
		wr(OFS_IRQEN, 8'h00);
		wr(OFS_SYNTH, 8'h0F);
		repeat (1000) @(posedge clk);
		rd(OFS_FLAGS, d);
		chk("settle change", d & 8'h10, 8'h10);
		chk("irq", {7'h00, irqReq}, 8'h00);
		$display("test lock interrupt done");
		complete_run();
	end
endmodule

`default_nettype wire
